// ### ppm_pkg.sv
// package: constants and types for the power mode and presence sequencer
package ppm_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ           = 20000000;
  localparam int unsigned UPDATE_PERIOD_MS = 1000;
  localparam int unsigned UPDATE_CYCLES    = CLK_HZ / 1000 * UPDATE_PERIOD_MS;
  localparam int unsigned MS_CYCLES        = CLK_HZ / 1000;
  // short sample period: a pulled pack is caught within a millisecond
  localparam int unsigned PACK_PRESENT_N_SAMPLE_MS   = 1;
  localparam int unsigned PACK_PRESENT_N_CYCLES      = MS_CYCLES * PACK_PRESENT_N_SAMPLE_MS;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_SLEEP_INT = 8'h04;
  localparam logic [7:0] OFS_WAKE_LVL  = 8'h08;
  localparam logic [7:0] OFS_CAL_TIME  = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;
  // control register fields
  localparam int CTRL_SLEEP_REQ = 0;
  localparam int CTRL_SHUT_REQ  = 1;
  localparam int CTRL_WAKE_EN   = 2;
  localparam int CTRL_NONREMOVE = 3;
  localparam int CTRL_SW_REQ    = 4;
  // irq status fields
  localparam int IRQ_CYCLE   = 0;
  localparam int IRQ_WAKE    = 1;
  localparam int IRQ_REMOVED = 2;
  localparam int IRQ_CAL     = 3;
  localparam int IRQ_W       = 4;
  // reset values
  localparam logic [31:0] SLEEP_INT_RST = 32'h0000_000a;
  localparam logic [15:0] WAKE_LVL_RST  = 16'h0100;
  localparam logic [15:0] CAL_TIME_RST  = 16'h07d0;
  localparam logic [4:0]  CTRL_RST      = 5'h00;

  typedef enum logic [1:0] {
    PPM_NORMAL   = 2'b00,
    PPM_SLEEP    = 2'b01,
    PPM_SHUTDOWN = 2'b10
  } ppm_mode_e;

  typedef struct packed {
    logic chg_en;
    logic dsg_en;
    logic zvc_en;
  } ppm_sw_s;
endpackage

// ### ppm_tick.sv
// file: interval counter producing a one-cycle tick
`timescale 1ns/1ps
module ppm_tick #(
  parameter int W = 32
) (
  input  wire logic         pclk,    // system clock
  input  wire logic         presetn, // async reset, active low
  input  wire logic         run,     // count while high
  input  wire logic [W-1:0] limit,   // ticks every limit cycles
  output logic              tick     // one-cycle pulse
);
  logic [W-1:0] cnt;      // current count
  logic [W-1:0] next_cnt; // next count
  logic         next_tick;

  // count up, wrap at limit; a stopped counter restarts from zero
  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = '0;
    end else if (cnt + W'(1) >= limit) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + W'(1);
    end
  end

  // register only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// ### ppm_ctrl.sv
// file: power mode sequencer, pack presence monitor and apb registers
// Behaviour
// RULE1 - three modes: normal, sleep, shutdown
// RULE2 - normal mode: update cycle every second
// RULE3 - reduced power between update cycles
// RULE4 - sleep mode: update at programmable interval
// RULE5 - wake to normal on current or fault
// RULE6 - shutdown stops all update activity
// RULE7 - sample presence; low means installed, normal
// RULE8 - presence high: removed, switches off
// RULE9 - non-removable config ignores presence input
// RULE10 - current wake only when enabled, at level
// RULE11 - bus lines low long: start calibration
// RULE12 - reset: normal, switches off until sampled
`timescale 1ns/1ps
module ppm_ctrl
  import ppm_pkg::*;
(
  input  wire logic        pclk,          // system clock, 20 MHz
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic [31:0]      prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic        pack_present_n,// presence pin, low = installed
  input  wire logic [15:0] sense_pos_in,  // sensed current, positive side
  input  wire logic [15:0] sense_neg_in,  // sensed current, negative side
  input  wire logic        fault_in,      // failure detected (pin)
  input  wire logic        smb_clk_in,    // bus clock line level
  input  wire logic        smb_data_in,   // bus data line level
  input  wire logic        safety_ok,     // protection allows switches
  output logic             update_start,  // update cycle trigger pulse
  output logic             low_power,     // reduced power stage
  output logic             cal_start,     // offset calibration pulse
  output logic [1:0]       power_mode,    // current mode code
  output logic             chg_switch_en, // charge switch enable
  output logic             dsg_switch_en, // discharge switch enable
  output logic             zero_volt_charge_switch_en, // zero-volt switch
  output logic             irq            // level interrupt
);
  // pin synchronisers: first stage read only by second
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 4'hf;
      sync2 <= 4'hf;
    end else begin
      sync1 <= {pack_present_n, fault_in, smb_clk_in, smb_data_in};
      sync2 <= sync1;
    end
  end
  logic pack_present_n_n_s;  // synced presence
  logic fault_s;   // synced fault
  logic smbc_s;    // synced bus clock
  logic smbd_s;    // synced bus data
  assign pack_present_n_n_s = sync2[3];
  assign fault_s  = sync2[2];
  assign smbc_s   = sync2[1];
  assign smbd_s   = sync2[0];

  // software registers
  logic [4:0]        ctrl;       // control bits
  logic [31:0]       sleep_int;  // sleep interval in seconds
  logic [15:0]       wake_lvl;   // current wake level
  logic [15:0]       cal_time;   // calibration low time in ms
  logic [IRQ_W-1:0]  irq_stat;   // sticky events
  logic [IRQ_W-1:0]  irq_mask;   // enables
  logic [4:0]        next_ctrl;
  logic [31:0]       next_sleep_int;
  logic [15:0]       next_wake_lvl;
  logic [15:0]       next_cal_time;
  logic [IRQ_W-1:0]  next_irq_stat;
  logic [IRQ_W-1:0]  next_irq_mask;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;

  // sequencer state
  ppm_mode_e mode;
  ppm_mode_e next_mode;
  logic      present;       // pack seen installed
  logic      sampled;       // first presence sample taken
  logic      next_present;
  logic      next_sampled;
  logic [IRQ_W-1:0] ev;     // events this cycle

  // apb: decoded on the first access edge, ready one cycle later
  logic acc;
  logic wr;
  assign acc = psel && penable && !pready;
  // writes land only at the edge where the master sees ready high
  assign wr  = psel && penable && pready && pwrite;

  // time bases
  logic ms_tick;     // one millisecond enable
  logic sec_tick;    // one second enable
  logic pack_present_n_tick;   // presence sample enable
  logic upd_run;     // update counter runs outside shutdown
  logic slp_tick;    // sleep interval elapsed
  ppm_tick #(.W(32)) u_sec (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (upd_run),
    .limit   (32'(UPDATE_CYCLES)),
    .tick    (sec_tick)
  );
  ppm_tick #(.W(16)) u_ms (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (1'b1),
    .limit   (16'(MS_CYCLES)),
    .tick    (ms_tick)
  );
  ppm_tick #(.W(24)) u_pack_present_n (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (1'b1),
    .limit   (24'(PACK_PRESENT_N_CYCLES)),
    .tick    (pack_present_n_tick)
  );
  // shutdown halts the update time base entirely
  // RULE6 stop time base
  assign upd_run = (mode != PPM_SHUTDOWN);

  // sleep interval counted in seconds
  logic [31:0] slp_cnt;
  logic [31:0] next_slp_cnt;
  // RULE4 sleep interval count
  always_comb begin
    next_slp_cnt = slp_cnt;
    slp_tick     = 1'b0;
    if (mode != PPM_SLEEP) begin
      next_slp_cnt = '0;
    end else if (sec_tick) begin
      if (slp_cnt + 32'd1 >= sleep_int) begin
        next_slp_cnt = '0;
        slp_tick     = 1'b1;
      end else begin
        next_slp_cnt = slp_cnt + 32'd1;
      end
    end
  end

  // current wake: magnitude of differential at or above level
  logic [15:0] diff_mag;
  logic        cur_wake;
  assign diff_mag = (sense_pos_in >= sense_neg_in) ? sense_pos_in - sense_neg_in
                                                   : sense_neg_in - sense_pos_in;
  // RULE10 gated current wake
  assign cur_wake = ctrl[CTRL_WAKE_EN] && (diff_mag >= wake_lvl);

  // bus-low timer for calibration, in ms
  logic [15:0] low_ms;
  logic [15:0] next_low_ms;
  logic        cal_done;      // fired once per low period
  logic        next_cal_done;
  logic        next_cal_start;
  // RULE11 bus low calibration
  always_comb begin
    next_low_ms    = low_ms;
    next_cal_done  = cal_done;
    next_cal_start = 1'b0;
    if (smbc_s || smbd_s) begin
      next_low_ms   = '0;
      next_cal_done = 1'b0;
    end else if (ms_tick && !cal_done) begin
      // first tick may come at once; one extra tick keeps the time a minimum
      if (low_ms >= cal_time) begin
        next_cal_start = 1'b1;
        next_cal_done  = 1'b1;
      end else begin
        next_low_ms = low_ms + 16'd1;
      end
    end
  end

  // mode sequencer and presence evaluation
  logic next_update;
  always_comb begin
    next_mode    = mode;
    next_present = present;
    next_sampled = sampled;
    next_update  = 1'b0;
    ev           = '0;
    // RULE9 ignore presence
    if (ctrl[CTRL_NONREMOVE]) begin
      next_present = 1'b1;
      next_sampled = 1'b1;
    // RULE7 periodic presence sample
    end else if (pack_present_n_tick) begin
      next_sampled = 1'b1;
      next_present = !pack_present_n_n_s;
      // RULE8 removal event
      if (pack_present_n_n_s && present) begin
        ev[IRQ_REMOVED] = 1'b1;
      end
    end
    // RULE1 mode selection
    unique case (mode)
      PPM_NORMAL: begin
        // RULE2 one second cycle
        next_update = sec_tick;
        if (ctrl[CTRL_SHUT_REQ]) begin
          next_mode = PPM_SHUTDOWN;
        end else if (ctrl[CTRL_SLEEP_REQ] && !cur_wake && !fault_s) begin
          next_mode = PPM_SLEEP;
        end
      end
      PPM_SLEEP: begin
        next_update = slp_tick;
        if (ctrl[CTRL_SHUT_REQ]) begin
          next_mode = PPM_SHUTDOWN;
        // RULE5 wake on current or fault
        end else if (cur_wake || fault_s) begin
          next_mode     = PPM_NORMAL;
          ev[IRQ_WAKE]  = 1'b1;
        end
      end
      PPM_SHUTDOWN: begin
        // only clearing the request leaves shutdown
        if (!ctrl[CTRL_SHUT_REQ]) begin
          next_mode = PPM_NORMAL;
        end
      end
      default: begin
        next_mode = PPM_NORMAL;
      end
    endcase
    // RULE7 newly installed pack seen in sleep forces normal
    if (pack_present_n_tick && !ctrl[CTRL_NONREMOVE] && !pack_present_n_n_s && !present && mode == PPM_SLEEP) begin
      next_mode = PPM_NORMAL;
    end
    ev[IRQ_CYCLE] = next_update;
    ev[IRQ_CAL]   = next_cal_start;
  end

  // switch enables: removed or unsampled pack keeps all off
  ppm_sw_s next_sw;
  always_comb begin
    next_sw = '0;
    // RULE12 off until sampled
    // RULE8 removed state disables switches
    if (sampled && present && mode != PPM_SHUTDOWN && safety_ok) begin
      next_sw.chg_en = ctrl[CTRL_SW_REQ];
      next_sw.dsg_en = ctrl[CTRL_SW_REQ];
      next_sw.zvc_en = ctrl[CTRL_SW_REQ];
    end
  end

  // register file next values
  always_comb begin
    next_ctrl      = ctrl;
    next_sleep_int = sleep_int;
    next_wake_lvl  = wake_lvl;
    next_cal_time  = cal_time;
    next_irq_mask  = irq_mask;
    next_irq_stat  = irq_stat;
    next_prdata    = prdata;
    next_pready    = acc;
    next_pslverr   = 1'b0;
    // answer decoded on the first access edge, both directions
    if (acc) begin
      unique case (paddr)
        OFS_CTRL:      next_prdata = {27'h0, ctrl};
        OFS_SLEEP_INT: next_prdata = sleep_int;
        OFS_WAKE_LVL:  next_prdata = {16'h0, wake_lvl};
        OFS_CAL_TIME:  next_prdata = {16'h0, cal_time};
        OFS_STATUS:    next_prdata = {26'h0, sampled, present, low_power, 1'b0, mode};
        OFS_IRQ_STAT:  next_prdata = {28'h0, irq_stat};
        OFS_IRQ_MASK:  next_prdata = {28'h0, irq_mask};
        default: begin
          next_prdata  = 32'h0;
          next_pslverr = 1'b1;
        end
      endcase
      // a write leaves the last read data standing
      if (pwrite) begin
        next_prdata = prdata;
      end
    end
    // write commits at the ready edge
    if (wr) begin
      unique case (paddr)
        OFS_CTRL:      next_ctrl      = pwdata[4:0];
        OFS_SLEEP_INT: next_sleep_int = pwdata;
        OFS_WAKE_LVL:  next_wake_lvl  = pwdata[15:0];
        OFS_CAL_TIME:  next_cal_time  = pwdata[15:0];
        OFS_IRQ_STAT:  next_irq_stat  = irq_stat & ~pwdata[IRQ_W-1:0];
        OFS_IRQ_MASK:  next_irq_mask  = pwdata[IRQ_W-1:0];
        // status is read-only, unmapped was refused already
        default: begin
        end
      endcase
    end
    // set wins over a same-cycle clear
    next_irq_stat = next_irq_stat | ev;
  end

  // RULE3 reduced power between cycles
  logic next_low_power;
  assign next_low_power = (next_mode != PPM_SHUTDOWN) && !next_update;

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // RULE12 reset into normal
      mode          <= PPM_NORMAL;
      present       <= 1'b0;
      sampled       <= 1'b0;
      slp_cnt       <= '0;
      low_ms        <= '0;
      cal_done      <= 1'b0;
      ctrl          <= CTRL_RST;
      sleep_int     <= SLEEP_INT_RST;
      wake_lvl      <= WAKE_LVL_RST;
      cal_time      <= CAL_TIME_RST;
      irq_stat      <= '0;
      irq_mask      <= '0;
      prdata        <= 32'h0;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      update_start  <= 1'b0;
      low_power     <= 1'b0;
      cal_start     <= 1'b0;
      power_mode    <= PPM_NORMAL;
      chg_switch_en <= 1'b0;
      dsg_switch_en <= 1'b0;
      zero_volt_charge_switch_en <= 1'b0;
      irq           <= 1'b0;
    end else begin
      mode          <= next_mode;
      present       <= next_present;
      sampled       <= next_sampled;
      slp_cnt       <= next_slp_cnt;
      low_ms        <= next_low_ms;
      cal_done      <= next_cal_done;
      ctrl          <= next_ctrl;
      sleep_int     <= next_sleep_int;
      wake_lvl      <= next_wake_lvl;
      cal_time      <= next_cal_time;
      irq_stat      <= next_irq_stat;
      irq_mask      <= next_irq_mask;
      prdata        <= next_prdata;
      pready        <= next_pready;
      pslverr       <= next_pslverr;
      update_start  <= next_update;
      low_power     <= next_low_power;
      cal_start     <= next_cal_start;
      power_mode    <= next_mode;
      chg_switch_en <= next_sw.chg_en;
      dsg_switch_en <= next_sw.dsg_en;
      zero_volt_charge_switch_en <= next_sw.zvc_en;
      irq           <= |(next_irq_stat & next_irq_mask);
    end
  end
endmodule

// ### ppm_ctrl_properties.sv
// checker: port-level properties of the power mode sequencer
`timescale 1ns/1ps
module ppm_ctrl_chk
  import ppm_pkg::*;
(
  input wire logic       pclk,                      // clock
  input wire logic       presetn,                   // reset, active low
  input wire logic       pready,                    // apb ready
  input wire logic       fault_in,                  // failure pin
  input wire logic       smb_clk_in,                // bus clock line
  input wire logic       smb_data_in,               // bus data line
  input wire logic       update_start,              // update pulse
  input wire logic       low_power,                 // reduced power
  input wire logic       cal_start,                 // calibration pulse
  input wire logic [1:0] power_mode,                // mode code
  input wire logic       chg_switch_en,             // charge switch
  input wire logic       dsg_switch_en,             // discharge switch
  input wire logic       zero_volt_charge_switch_en // zero-volt switch
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // all three switch enables off
  sequence sw_off;
    !chg_switch_en && !dsg_switch_en && !zero_volt_charge_switch_en;
  endsequence
  // powered and between update cycles
  sequence idle_on;
    power_mode != PPM_SHUTDOWN && !update_start;
  endsequence
  // asleep while a failure is present
  sequence fault_sleep;
    power_mode == PPM_SLEEP && fault_in;
  endsequence
  mode_legal_a: assert property (power_mode != 2'b11)
    else $error("mode code outside the three modes");
  reset_safe_a: assert property ($rose(presetn) |-> power_mode == PPM_NORMAL ##0 sw_off [*3])
    else $error("not normal with switches off after reset");
  // two cycles of slack for the registered stage output
  idle_low_power_a: assert property (idle_on [*3] |-> low_power)
    else $error("awake between cycles without reduced power");
  update_awake_a: assert property (update_start |-> !low_power ##1 !update_start)
    else $error("update pulse too long or in reduced power");
  shut_quiet_a: assert property (power_mode == PPM_SHUTDOWN [*2] |-> !update_start && !low_power)
    else $error("activity seen in shutdown");
  // two sync flops plus state register fit in the window
  fault_wake_a: assert property (fault_sleep [*4] |-> ##[0:3] power_mode == PPM_NORMAL)
    else $error("failure did not wake to normal");
  cal_bus_low_a: assert property (cal_start |-> !$past(smb_clk_in, 3) && !$past(smb_data_in, 3) ##1 !cal_start)
    else $error("calibration without both bus lines low");
  ready_pulse_a: assert property (pready |-> ##1 !pready)
    else $error("ready held longer than one cycle");
endmodule

bind ppm_ctrl ppm_ctrl_chk u_chk (
  .pclk(pclk), .presetn(presetn), .pready(pready), .fault_in(fault_in),
  .smb_clk_in(smb_clk_in), .smb_data_in(smb_data_in), .update_start(update_start),
  .low_power(low_power), .cal_start(cal_start), .power_mode(power_mode),
  .chg_switch_en(chg_switch_en), .dsg_switch_en(dsg_switch_en),
  .zero_volt_charge_switch_en(zero_volt_charge_switch_en)
);

// ### ppm_pack_model.sv
// model: host presence contact, bus lines and pack switch drivers
`timescale 1ns/1ps
module ppm_pack_model
  import ppm_pkg::*;
(
  input  wire logic    installed,      // pack seated in the host
  input  wire logic    bus_low,        // host holds both bus lines low
  input  wire ppm_sw_s sw,             // switch drives from the gauge
  output logic         pack_present_n, // contact, pulled up when out
  output logic         smb_clk_in,     // bus clock, pulled up when idle
  output logic         smb_data_in,    // bus data, pulled up when idle
  output logic         fets_on         // all switches closed
);
  // removed pack leaves the contact to its pull-up
  assign pack_present_n = !installed;
  // released lines go to their pull-ups
  assign smb_clk_in  = !bus_low;
  assign smb_data_in = !bus_low;
  // drivers close only when every enable is asserted
  assign fets_on = sw.chg_en && sw.dsg_en && sw.zvc_en;
endmodule

// ### tb_top.sv
// testbench: power mode sequencer, presence and apb registers
`timescale 1ns/1ps
module tb_top
  import ppm_pkg::*;
();
  logic        pclk, presetn, psel, penable, pwrite;   // clock, reset, apb
  logic [7:0]  paddr;                                  // apb address
  logic [31:0] pwdata, prdata, rd;                     // apb data
  logic        pready, pslverr, er;                    // apb answer
  logic [15:0] sense_pos_in, sense_neg_in;             // current codes
  logic        fault_in, safety_ok, installed, bus_low; // stimulus levels
  logic        pack_present_n, smb_clk_in, smb_data_in; // model lines
  logic        update_start, low_power, cal_start, irq, fets_on;
  logic [1:0]  power_mode;                             // mode code
  logic        chg_switch_en, dsg_switch_en, zero_volt_charge_switch_en;
  ppm_sw_s     sw;                                     // switch bundle
  int          n_errors, cmp_count;                    // tallies
  assign sw = {chg_switch_en, dsg_switch_en, zero_volt_charge_switch_en};
  ppm_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pack_present_n(pack_present_n), .sense_pos_in(sense_pos_in), .sense_neg_in(sense_neg_in),
    .fault_in(fault_in), .smb_clk_in(smb_clk_in), .smb_data_in(smb_data_in), .safety_ok(safety_ok),
    .update_start(update_start), .low_power(low_power), .cal_start(cal_start), .power_mode(power_mode),
    .chg_switch_en(chg_switch_en), .dsg_switch_en(dsg_switch_en),
    .zero_volt_charge_switch_en(zero_volt_charge_switch_en), .irq(irq));
  ppm_pack_model u_pack (.installed(installed), .bus_low(bus_low), .sw(sw),
    .pack_present_n(pack_present_n), .smb_clk_in(smb_clk_in), .smb_data_in(smb_data_in), .fets_on(fets_on));
  // closing report, also reached by any timeout
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("apb ready", 32'h1, 32'(pready));
      end_sim();
    end
  endtask
  // bounded wait for a mode, then compare it
  task automatic wait_mode(input logic [1:0] m, input string nm);
    int k;
    k = 0;
    while (power_mode !== m && k < 64) begin
      @(posedge pclk);
      k++;
    end
    chk(nm, 32'(m), 32'(power_mode));
    if (power_mode !== m) end_sim();
  endtask
  task automatic t_regs();
    logic [7:0]  ad [5] = '{OFS_CTRL, OFS_SLEEP_INT, OFS_WAKE_LVL, OFS_CAL_TIME, OFS_IRQ_MASK};
    logic [31:0] ex [5] = '{32'h0, SLEEP_INT_RST, 32'(WAKE_LVL_RST), 32'(CAL_TIME_RST), 32'h0};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ad[i], 32'h0);
      chk("reset value", ex[i], rd);
    end
    chk("reset mode", 32'(PPM_NORMAL), 32'(power_mode));
    chk("reset switches", 32'h0, 32'(sw));
    apb(1'b1, OFS_SLEEP_INT, 32'h3);
    apb(1'b0, OFS_SLEEP_INT, 32'h0);
    chk("sleep interval", 32'h3, rd);
    // read-only status ignores writes without error
    apb(1'b1, OFS_STATUS, 32'hffff_ffff);
    chk("status err", 32'h0, 32'(er));
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status mode", 32'h0, 32'(rd[1:0]));
    chk("status sampled", 32'h0, 32'(rd[5]));
    apb(1'b1, 8'h1c, 32'hffff_ffff);
    chk("unmapped err", 32'h1, 32'(er));
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped data", 32'h0, rd);
    $display("done: registers");
  endtask
  // wake exactly at the level, current in the negative direction
  task automatic t_wake();
    apb(1'b1, OFS_WAKE_LVL, 32'h40);
    sense_pos_in <= 16'h3f;
    apb(1'b1, OFS_CTRL, 32'h5);
    wait_mode(PPM_SLEEP, "enter sleep");
    repeat (20) @(posedge pclk);
    chk("below level", 32'(PPM_SLEEP), 32'(power_mode));
    chk("sleep low power", 32'h1, 32'(low_power));
    sense_neg_in <= 16'h7f;
    wait_mode(PPM_NORMAL, "current wake");
    apb(1'b1, OFS_CTRL, 32'h0);
    sense_neg_in <= 16'h0;
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("wake flag", 32'h1, 32'(rd[IRQ_WAKE]));
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq raised", 32'h1, 32'(irq));
    apb(1'b1, OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, 32'(irq));
    $display("done: current wake");
  endtask
  task automatic t_fault();
    apb(1'b1, OFS_CTRL, 32'h1);
    wait_mode(PPM_SLEEP, "sleep again");
    fault_in <= 1'b1;
    wait_mode(PPM_NORMAL, "fault wake");
    apb(1'b1, OFS_CTRL, 32'h0);
    fault_in <= 1'b0;
    $display("done: fault wake");
  endtask
  task automatic t_shut();
    int bad;
    bad = 0;
    apb(1'b1, OFS_CTRL, 32'h2);
    wait_mode(PPM_SHUTDOWN, "enter shutdown");
    repeat (30) begin
      @(posedge pclk);
      bad += int'(update_start !== 1'b0 || low_power !== 1'b0);
    end
    chk("shutdown quiet", 32'h0, 32'(bad));
    apb(1'b1, OFS_CTRL, 32'h0);
    wait_mode(PPM_NORMAL, "leave shutdown");
    $display("done: shutdown");
  endtask
  // pack reads as removed, yet non-removable mode lets switches on
  task automatic t_switch();
    int k;
    k = 0;
    installed <= 1'b0;
    safety_ok <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h18);
    while (fets_on !== 1'b1 && k < 64) begin
      @(posedge pclk);
      k++;
    end
    chk("switches on", 32'h1, 32'(fets_on));
    if (fets_on !== 1'b1) end_sim();
    // presence honoured again: removed pack drops every switch
    apb(1'b1, OFS_CTRL, 32'h10);
    k = 0;
    while (fets_on !== 1'b0 && k < 21000) begin
      @(posedge pclk);
      k++;
    end
    chk("removed switches", 32'h0, 32'(sw));
    if (sw !== 3'h0) end_sim();
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("removed flag", 32'h1, 32'(rd[IRQ_REMOVED]));
    installed <= 1'b1;
    k = 0;
    while (fets_on !== 1'b1 && k < 21000) begin
      @(posedge pclk);
      k++;
    end
    chk("installed switches", 32'h1, 32'(fets_on));
    if (fets_on !== 1'b1) end_sim();
    $display("done: non-removable");
  endtask
  task automatic t_cal();
    int k;
    k = 0;
    apb(1'b1, OFS_CAL_TIME, 32'h1);
    bus_low <= 1'b1;
    while (cal_start !== 1'b1 && k < 42000) begin
      @(posedge pclk);
      k++;
    end
    chk("cal start", 32'h1, 32'(cal_start));
    if (cal_start !== 1'b1) end_sim();
    chk("cal not early", 32'h1, 32'(k >= MS_CYCLES - 2));
    bus_low <= 1'b0;
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("cal flag", 32'h1, 32'(rd[IRQ_CAL]));
    $display("done: calibration");
  endtask
  // free-running 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // reset, then the scenarios in turn
  initial begin
    {presetn, psel, penable, pwrite, fault_in, safety_ok, bus_low} = 7'h0;
    {paddr, pwdata, sense_pos_in, sense_neg_in} = 72'h0;
    installed = 1'b1;
    n_errors  = 0;
    cmp_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_wake();
    t_fault();
    t_shut();
    t_switch();
    t_cal();
    end_sim();
  end
endmodule
